// [hdl/sbst_tap.sv]
// boundary scan test access port of the burst sram
`timescale 1ns/1ps
`default_nettype none
`include "sbst_defs.svh"

module sbst_tap #(
  parameter bit WIDE_CFG = 1'b1
) (
  // memory clock domain
  input wire logic clk,
  input wire logic rst,
  // io ring seen by the boundary register
  input wire logic [`SBST_BSR_X36-1:0] ring_i,
  // memory output float request, memory clock domain
  output logic mem_out_hiz_o,
  // test link
  input wire logic tck,
  input wire logic tms_i,
  input wire logic tdi_i,
  output logic tdo_o,
  output logic tdo_oe_n_o
);

  localparam int unsigned BSR_LEN = WIDE_CFG ? `SBST_BSR_X36 : `SBST_BSR_X18;
  localparam logic [`SBST_BSR_X36-1:0] BSR_MASK =
    {`SBST_BSR_X36{1'b1}} >> (`SBST_BSR_X36 - BSR_LEN);

  sbst_pkg::sbst_tck_t cur, nxt;
  sbst_pkg::sbst_neg_t ncur, nnxt;
  sbst_pkg::sbst_clk_t ccur, cnxt;

  logic tck_rst;
  logic req_s;
  logic ack_s;
  logic sel_bsr;
  logic sel_id;
  logic sel_byp;
  logic [`SBST_BSR_X36-1:0] bsr_step;

  // reset reaches the test domain through two flops; the sync itself has
  // no reset so it settles on its own once rst is held
  sbst_sync2 #(.WIDTH(1)) u_rst_sync (
    .clk(tck),
    .rst(1'b0),
    .d_async(rst),
    .q(tck_rst)
  );

  sbst_sync2 #(.WIDTH(1)) u_req_sync (
    .clk(tck),
    .rst(tck_rst),
    .d_async(ccur.tgl),
    .q(req_s)
  );

  sbst_sync2 #(.WIDTH(1)) u_ack_sync (
    .clk(clk),
    .rst(rst),
    .d_async(cur.seen),
    .q(ack_s)
  );

  // float request is an instruction level, the memory side only sees a
  // synchronised copy so memory timing never hangs on the test clock
  sbst_sync2 #(.WIDTH(1)) u_hiz_sync (
    .clk(clk),
    .rst(rst),
    .d_async(cur.hiz_req),
    .q(mem_out_hiz_o)
  );

  // memory side: snapshot the ring and offer it by a toggle handshake
  always_comb begin
    cnxt = ccur;
    if (ack_s == ccur.tgl) begin
      cnxt.snap = ring_i & BSR_MASK;
      cnxt.tgl = ~ccur.tgl;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      ccur <= '0;
    end else begin
      ccur <= cnxt;
    end
  end

  // the current instruction picks exactly one register for the scan path;
  // reserved codes land on bypass so a chain through this port never breaks
  always_comb begin
    sel_bsr = 1'b0;
    sel_id = 1'b0;
    sel_byp = 1'b0;
    case (cur.ir)
      `SBST_IR_EXTEST, `SBST_IR_SAMPLE, `SBST_IR_SAMPLEZ: begin
        sel_bsr = 1'b1;
      end
      `SBST_IR_IDCODE: begin
        sel_id = 1'b1;
      end
      default: begin
        sel_byp = 1'b1;
      end
    endcase
  end

  // boundary shift path; stages above the build's length stay zero so the
  // narrow build puts exactly its own length between tdi and tdo
  genvar gb;
  generate
    for (gb = 0; gb < `SBST_BSR_X36; gb++) begin : g_bsr
      if (gb == BSR_LEN - 1) begin : g_top
        assign bsr_step[gb] = tdi_i;
      end else if (gb < BSR_LEN - 1) begin : g_mid
        assign bsr_step[gb] = cur.bsr[gb + 1];
      end else begin : g_pad
        assign bsr_step[gb] = 1'b0;
      end
    end
  endgenerate

  // tap state sequence; tms pull-up lives in the pad, an open pin reads 1
  always_comb begin
    nxt = cur;
    case (cur.state)
      sbst_pkg::SBST_TLR: begin
        nxt.state = tms_i ? sbst_pkg::SBST_TLR : sbst_pkg::SBST_RTI;
      end
      sbst_pkg::SBST_RTI: begin
        nxt.state = tms_i ? sbst_pkg::SBST_SEL_DR : sbst_pkg::SBST_RTI;
      end
      sbst_pkg::SBST_SEL_DR: begin
        nxt.state = tms_i ? sbst_pkg::SBST_SEL_IR : sbst_pkg::SBST_CAP_DR;
      end
      sbst_pkg::SBST_CAP_DR: begin
        nxt.state = tms_i ? sbst_pkg::SBST_EX1_DR : sbst_pkg::SBST_SH_DR;
      end
      sbst_pkg::SBST_SH_DR: begin
        nxt.state = tms_i ? sbst_pkg::SBST_EX1_DR : sbst_pkg::SBST_SH_DR;
      end
      sbst_pkg::SBST_EX1_DR: begin
        nxt.state = tms_i ? sbst_pkg::SBST_UPD_DR : sbst_pkg::SBST_PA_DR;
      end
      sbst_pkg::SBST_PA_DR: begin
        nxt.state = tms_i ? sbst_pkg::SBST_EX2_DR : sbst_pkg::SBST_PA_DR;
      end
      sbst_pkg::SBST_EX2_DR: begin
        nxt.state = tms_i ? sbst_pkg::SBST_UPD_DR : sbst_pkg::SBST_SH_DR;
      end
      sbst_pkg::SBST_UPD_DR: begin
        nxt.state = tms_i ? sbst_pkg::SBST_SEL_DR : sbst_pkg::SBST_RTI;
      end
      sbst_pkg::SBST_SEL_IR: begin
        nxt.state = tms_i ? sbst_pkg::SBST_TLR : sbst_pkg::SBST_CAP_IR;
      end
      sbst_pkg::SBST_CAP_IR: begin
        nxt.state = tms_i ? sbst_pkg::SBST_EX1_IR : sbst_pkg::SBST_SH_IR;
      end
      sbst_pkg::SBST_SH_IR: begin
        nxt.state = tms_i ? sbst_pkg::SBST_EX1_IR : sbst_pkg::SBST_SH_IR;
      end
      sbst_pkg::SBST_EX1_IR: begin
        nxt.state = tms_i ? sbst_pkg::SBST_UPD_IR : sbst_pkg::SBST_PA_IR;
      end
      sbst_pkg::SBST_PA_IR: begin
        nxt.state = tms_i ? sbst_pkg::SBST_EX2_IR : sbst_pkg::SBST_PA_IR;
      end
      sbst_pkg::SBST_EX2_IR: begin
        nxt.state = tms_i ? sbst_pkg::SBST_UPD_IR : sbst_pkg::SBST_SH_IR;
      end
      sbst_pkg::SBST_UPD_IR: begin
        nxt.state = tms_i ? sbst_pkg::SBST_SEL_DR : sbst_pkg::SBST_RTI;
      end
      default: begin
        nxt.state = sbst_pkg::SBST_TLR;
      end
    endcase

    // take a fresh ring snapshot from the memory side
    if (req_s != cur.seen) begin
      nxt.ring = ccur.snap;
      nxt.seen = req_s;
    end

    case (cur.state)
      sbst_pkg::SBST_TLR: begin
        nxt.ir = `SBST_IR_IDCODE;
        nxt.ir_sh = `SBST_IR_IDCODE;
      end
      sbst_pkg::SBST_CAP_IR: begin
        nxt.ir_sh = `SBST_IR_CAPTURE;
      end
      sbst_pkg::SBST_SH_IR: begin
        nxt.ir_sh = {tdi_i, cur.ir_sh[`SBST_IR_W-1:1]};
      end
      sbst_pkg::SBST_UPD_IR: begin
        nxt.ir = cur.ir_sh;
      end
      sbst_pkg::SBST_CAP_DR: begin
        case (cur.ir)
          `SBST_IR_EXTEST, `SBST_IR_SAMPLE, `SBST_IR_SAMPLEZ: begin
            nxt.bsr = cur.ring & BSR_MASK;
          end
          `SBST_IR_IDCODE: begin
            nxt.id_sh = `SBST_ID_CODE;
          end
          default: begin
            nxt.byp = `SBST_BYP_CAPTURE;
          end
        endcase
      end
      sbst_pkg::SBST_SH_DR: begin
        case (cur.ir)
          `SBST_IR_EXTEST, `SBST_IR_SAMPLE, `SBST_IR_SAMPLEZ: begin
            nxt.bsr = bsr_step;
          end
          `SBST_IR_IDCODE: begin
            nxt.id_sh = {tdi_i, cur.id_sh[`SBST_ID_W-1:1]};
          end
          default: begin
            // reserved codes fall back to bypass so a chain never breaks
            nxt.byp = tdi_i;
          end
        endcase
      end
      // no preload: update-dr leaves everything as it is
      default: begin
      end
    endcase

    // float memory outputs while all-zeros or sample-floating is current
    nxt.hiz_req = (nxt.ir == `SBST_IR_EXTEST) || (nxt.ir == `SBST_IR_SAMPLEZ);
  end

  always_ff @(posedge tck) begin
    if (tck_rst) begin
      cur.state <= sbst_pkg::SBST_TLR;
      cur.ir <= `SBST_IR_IDCODE;
      cur.ir_sh <= `SBST_IR_IDCODE;
      cur.id_sh <= '0;
      cur.byp <= `SBST_BYP_CAPTURE;
      cur.bsr <= '0;
      cur.ring <= '0;
      cur.seen <= 1'b0;
      cur.hiz_req <= 1'b0;
    end else begin
      cur <= nxt;
    end
  end

  // serial output: lsb of the one selected register, driven only in shift
  always_comb begin
    nnxt.tdo = 1'b0;
    nnxt.tdo_oe_n = 1'b1;
    case (cur.state)
      sbst_pkg::SBST_SH_IR: begin
        nnxt.tdo = cur.ir_sh[0];
        nnxt.tdo_oe_n = 1'b0;
      end
      sbst_pkg::SBST_SH_DR: begin
        nnxt.tdo_oe_n = 1'b0;
        if (sel_bsr) begin
          nnxt.tdo = cur.bsr[0];
        end else if (sel_id) begin
          nnxt.tdo = cur.id_sh[0];
        end else if (sel_byp) begin
          nnxt.tdo = cur.byp;
        end
      end
      default: begin
        nnxt.tdo = 1'b0;
      end
    endcase
  end

  always_ff @(negedge tck) begin
    if (tck_rst) begin
      ncur <= '{tdo: 1'b0, tdo_oe_n: 1'b1};
    end else begin
      ncur <= nnxt;
    end
  end

  assign tdo_o = ncur.tdo;
  assign tdo_oe_n_o = ncur.tdo_oe_n;

endmodule : sbst_tap

`default_nettype wire

// [hdl/sbst_defs.svh]
// constants of the sram boundary scan test port
`ifndef SBST_DEFS_SVH
`define SBST_DEFS_SVH

// instruction register
`define SBST_IR_W 3
`define SBST_IR_EXTEST 3'h0
`define SBST_IR_IDCODE 3'h1
`define SBST_IR_SAMPLEZ 3'h2
`define SBST_IR_SAMPLE 3'h4
`define SBST_IR_BYPASS 3'h7
// pattern loaded in capture-ir, low two bits are 01
`define SBST_IR_CAPTURE 3'h1

// identification register, code value is arbitrary
`define SBST_ID_W 32
`define SBST_ID_CODE 32'h0ABC_DE01

// boundary scan register lengths
`define SBST_BSR_X36 72
`define SBST_BSR_X18 53

// bypass register value loaded in capture-dr
`define SBST_BYP_CAPTURE 1'h0

`endif

// [hdl/sbst_pkg.sv]
// types of the sram boundary scan test port
`include "sbst_defs.svh"

package sbst_pkg;

  typedef enum logic [15:0] {
    SBST_TLR    = 16'h0001,
    SBST_RTI    = 16'h0002,
    SBST_SEL_DR = 16'h0004,
    SBST_CAP_DR = 16'h0008,
    SBST_SH_DR  = 16'h0010,
    SBST_EX1_DR = 16'h0020,
    SBST_PA_DR  = 16'h0040,
    SBST_EX2_DR = 16'h0080,
    SBST_UPD_DR = 16'h0100,
    SBST_SEL_IR = 16'h0200,
    SBST_CAP_IR = 16'h0400,
    SBST_SH_IR  = 16'h0800,
    SBST_EX1_IR = 16'h1000,
    SBST_PA_IR  = 16'h2000,
    SBST_EX2_IR = 16'h4000,
    SBST_UPD_IR = 16'h8000
  } sbst_tap_t;

  // state clocked on rising test clock
  typedef struct packed {
    sbst_tap_t state;
    logic [`SBST_IR_W-1:0] ir;
    logic [`SBST_IR_W-1:0] ir_sh;
    logic [`SBST_ID_W-1:0] id_sh;
    logic byp;
    logic [`SBST_BSR_X36-1:0] bsr;
    logic [`SBST_BSR_X36-1:0] ring;
    logic seen;
    logic hiz_req;
  } sbst_tck_t;

  // state clocked on falling test clock
  typedef struct packed {
    logic tdo;
    logic tdo_oe_n;
  } sbst_neg_t;

  // state in the memory clock domain
  typedef struct packed {
    logic [`SBST_BSR_X36-1:0] snap;
    logic tgl;
  } sbst_clk_t;

endpackage : sbst_pkg

// [hdl/sbst_sync2.sv]
// two-flop synchroniser, one stage pair per bit
`timescale 1ns/1ps
`default_nettype none

module sbst_sync2 #(
  parameter int unsigned WIDTH = 1
) (
  // destination clock
  input wire logic clk,
  input wire logic rst,
  // data
  input wire logic [WIDTH-1:0] d_async,
  output logic [WIDTH-1:0] q
);

  logic [WIDTH-1:0] meta_ff;

  genvar gi;
  generate
    for (gi = 0; gi < WIDTH; gi++) begin : g_bit
      // first stage is read only by the second
      always_ff @(posedge clk) begin
        if (rst) begin
          meta_ff[gi] <= 1'b0;
          q[gi] <= 1'b0;
        end else begin
          meta_ff[gi] <= d_async[gi];
          q[gi] <= meta_ff[gi];
        end
      end
    end
  endgenerate

endmodule : sbst_sync2

`default_nettype wire

// [sim/sbst_host.sv]
// jtag controller model on the far side of the sram test port
`timescale 1ns/1ps
`default_nettype none

module sbst_host (
  // test link
  output logic tck,
  output logic tms,
  output logic tdi,
  input wire logic tdo
);
  // tck rests low between frames; tms and tdi rest at their pull-up level
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b1;
  end

  // edges sit 1.3 ns off the memory clock grid so the two clocks never share an edge
  task automatic step(input logic m, input logic d, output logic q);
    #11.3;
    tms = m;
    tdi = d;
    #12.0;
    q = tdo;
    tck = 1'b1;
    #24;
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b1;
    #0.7;
  endtask : step

  task automatic idle(input int n);
    logic q;
    repeat (n) step(1'b0, 1'b1, q);
  endtask : idle

  task automatic tap_reset;
    logic q;
    repeat (5) step(1'b1, 1'b1, q);
    step(1'b0, 1'b1, q);
  endtask : tap_reset

  // one whole scan from run-test-idle back to run-test-idle, lsb first
  task automatic scan(input bit ir, input int n, input logic [71:0] din, output logic [71:0] dout);
    logic q;
    dout = 72'h0;
    step(1'b1, 1'b1, q);
    if (ir) begin
      step(1'b1, 1'b1, q);
    end
    step(1'b0, 1'b1, q);
    step(1'b0, 1'b1, q);
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, din[i], q);
      dout[i] = q;
    end
    step(1'b1, 1'b1, q);
    step(1'b0, 1'b1, q);
  endtask : scan
endmodule : sbst_host
`default_nettype wire

// [sim/sbst_tap_props.sv]
// port assertions of the sram test port
`timescale 1ns/1ps
`default_nettype none
`include "sbst_defs.svh"

module sbst_tap_props #(
  parameter bit WIDE_CFG = 1'b1
) (
  // memory clock domain
  input wire logic clk,
  input wire logic rst,
  input wire logic [`SBST_BSR_X36-1:0] ring_i,
  input wire logic mem_out_hiz_o,
  // test link
  input wire logic tck,
  input wire logic tms_i,
  input wire logic tdi_i,
  input wire logic tdo_o,
  input wire logic tdo_oe_n_o
);
  logic [2:0] ones_ff;
  // saturates so a long high run never wraps back under five
  always_ff @(posedge tck) begin
    if (rst || !tms_i) begin
      ones_ff <= 3'h0;
    end else if (ones_ff != 3'h7) begin
      ones_ff <= ones_ff + 3'h1;
    end
  end

  tdo_fall_only_a: assert property (
    @(posedge clk) disable iff (rst) $changed(tdo_o) |-> !tck)
    else $error("tdo moved while test clock high");
  oe_fall_only_a: assert property (
    @(posedge clk) disable iff (rst) $changed(tdo_oe_n_o) |-> !tck)
    else $error("tdo enable moved while test clock high");
  tdo_idle_low_a: assert property (
    @(posedge clk) disable iff (rst) tdo_oe_n_o |-> !tdo_o)
    else $error("tdo not low while undriven");
  hiz_in_reset_a: assert property (
    @(posedge clk) rst ##1 rst |=> !mem_out_hiz_o)
    else $error("memory float during reset");
  hiz_rise_idle_a: assert property (
    @(posedge clk) disable iff (rst) $rose(mem_out_hiz_o) |-> tdo_oe_n_o)
    else $error("float began while shifting");
  // shift is entered from capture (1,0,0) or from exit2 after a pause (1,0)
  shift_entry_a: assert property (
    @(posedge tck) disable iff (rst) $fell(tdo_oe_n_o) |->
      !$past(tms_i) && ($past(tms_i, 2) || $past(tms_i, 3)))
    else $error("shift entered on wrong mode sequence");
  shift_hold_a: assert property (
    @(posedge tck) disable iff (rst) !$past(tdo_oe_n_o) |-> tdo_oe_n_o == $past(tms_i))
    else $error("shift state left or kept wrongly");
  tap_reset_a: assert property (
    @(posedge tck) disable iff (rst) ones_ff >= 3'h5 |-> tdo_oe_n_o)
    else $error("tdo driven after five high mode samples");

  cover property (@(posedge tck) $fell(tdo_oe_n_o));
  cover property (@(posedge clk) $rose(mem_out_hiz_o));
  cover property (@(posedge tck) ones_ff == 3'h5);
endmodule : sbst_tap_props

bind sbst_tap sbst_tap_props #(.WIDE_CFG(WIDE_CFG)) u_props (.clk(clk), .rst(rst), .ring_i(ring_i),
  .mem_out_hiz_o(mem_out_hiz_o), .tck(tck), .tms_i(tms_i), .tdi_i(tdi_i), .tdo_o(tdo_o),
  .tdo_oe_n_o(tdo_oe_n_o));
`default_nettype wire

// [sim/testbench.sv]
// self-checking bench of the sram test port
`timescale 1ns/1ps
`default_nettype none
`include "sbst_defs.svh"

module testbench;
  logic clk, rst, mem_out_hiz_o, tck, tms_i, tdi_i, tdo_o, tdo_oe_n_o;
  logic [71:0] ring_i, got, din;
  logic [31:0] seed;
  int fail_count, checked;

  sbst_tap #(.WIDE_CFG(1'b1)) u_dut (.clk(clk), .rst(rst), .ring_i(ring_i),
    .mem_out_hiz_o(mem_out_hiz_o), .tck(tck), .tms_i(tms_i), .tdi_i(tdi_i), .tdo_o(tdo_o),
    .tdo_oe_n_o(tdo_oe_n_o));
  sbst_host u_host (.tck(tck), .tms(tms_i), .tdi(tdi_i), .tdo(tdo_o));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction : lfsr

  // what the selected register shifts out, lsb first; the scan path is a
  // queue of captured bits that serial input joins at the far end
  function automatic logic [71:0] model_dr(input int code, input logic [71:0] ring,
    input logic [71:0] d, input int n);
    logic q[$];
    logic [71:0] cap;
    logic [71:0] r;
    int len;
    r = 72'h0;
    case (code)
      `SBST_IR_IDCODE: begin
        cap = {40'h0, `SBST_ID_CODE};
        len = `SBST_ID_W;
      end
      `SBST_IR_EXTEST, `SBST_IR_SAMPLEZ, `SBST_IR_SAMPLE: begin
        cap = ring;
        len = `SBST_BSR_X36;
      end
      default: begin
        cap = {71'h0, `SBST_BYP_CAPTURE};
        len = 1;
      end
    endcase
    for (int i = 0; i < len; i++) q.push_back(cap[i]);
    for (int i = 0; i < n; i++) q.push_back(d[i]);
    for (int i = 0; i < n; i++) r[i] = q.pop_front();
    return r;
  endfunction : model_dr

  task automatic check(input string what, input logic [71:0] e, input logic [71:0] s);
    checked++;
    if (s !== e) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", what, e, s);
    end
  endtask : check

  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : give_verdict

  initial begin
    int n;
    rst = 1'b1;
    ring_i = 72'h0;
    fail_count = 0;
    checked = 0;
    seed = 32'h9EB1A57D;
    // the test domain takes rst only on running tck edges
    fork
      repeat (10) @(posedge clk);
      u_host.tap_reset();
    join
    @(posedge clk);
    rst <= 1'b0;
    u_host.idle(4);
    u_host.scan(1'b0, 32, 72'hFF, got);
    check("idcode at power-up", model_dr(1, ring_i, 72'h0, 32), got);
    $display("power-up test done");
    for (int c = 0; c < 8; c++) begin
      seed = lfsr(seed);
      u_host.scan(1'b1, 3, 72'(c), got);
      check("ir capture", 72'h1, got);
      check("memory float", {71'h0, (c == 0 || c == 2)}, {71'h0, mem_out_hiz_o});
      @(posedge clk);
      ring_i <= {seed, lfsr(seed), seed[7:0]};
      din = {40'h0, lfsr(seed + 32'h1)};
      u_host.idle(10);
      n = (c == 1) ? 32 : (c == 0 || c == 2 || c == 4) ? `SBST_BSR_X36 : 8;
      u_host.scan(1'b0, n, din, got);
      check("dr scan", model_dr(c, ring_i, din, n), got);
      check("tdo enable at rest", 72'h1, {71'h0, tdo_oe_n_o});
      $display("instruction %0d test done", c);
    end
    u_host.scan(1'b1, 3, 72'h0, got);
    u_host.tap_reset();
    check("float after tap reset", 72'h0, {71'h0, mem_out_hiz_o});
    u_host.scan(1'b0, 32, 72'h0, got);
    check("idcode after tap reset", model_dr(1, ring_i, 72'h0, 32), got);
    $display("tap reset test done");
    give_verdict();
  end

  initial begin
    #300000;
    fail_count++;
    $display("watchdog expired");
    give_verdict();
  end
endmodule : testbench
`default_nettype wire
